// >>> inc/sar_adc_pkg.sv
// constants and carrier types for the two-channel sar converter control
// assumes an 8-bit special function register port from the cpu core
package sar_adc_pkg;

  localparam logic [7:0] ADDR_CLOCK_DIVIDER = 8'hF2;
  localparam logic [7:0] ADDR_CONTROL = 8'hF3;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'hF4;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'hF5;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // control register field positions
  localparam int CTRL_FREEZE_BIT = 6;
  localparam int CTRL_ENABLE_BIT = 5;
  localparam int CTRL_DONE_BIT = 4;
  localparam int CTRL_START_BIT = 3;
  localparam int CTRL_CHANNEL_BIT = 0;
  localparam logic [7:0] CTRL_WRITABLE_MASK = 8'h79;
  localparam logic [7:0] DIVIDER_WRITABLE_MASK = 8'h1F;
  localparam logic [7:0] LOW_WRITABLE_MASK = 8'h03;

  localparam logic [4:0] DIVIDER_ZERO = 5'h00;
  localparam logic [5:0] DIVIDER_ZERO_FACTOR = 6'h20;
  localparam logic [3:0] CONVERSION_PERIODS = 4'hB;

  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_READY,
    ST_CONVERTING
  } conv_state_e;

  // special function register access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

  // analog front end interface
  typedef struct packed {
    logic sample;
    logic channel_second;
    logic powered;
  } afe_ctrl_s;

endpackage

// >>> core/sar_adc_control.sv
// digital control of a two-channel 10-bit successive approximation converter
// assumes the core drives one sfr access per cycle; analog dac, comparator
// and sample-and-hold sit outside and answer with one bit per converter clock
//
// How it works
// RQ1: the converter clock is the peripheral clock divided by the 5-bit divider, 0 meaning 32.
// RQ2: channel select 0 converts the second analog input and 1 the first.
// RQ3: freeze plus start stalls the cpu until the conversion ends, then freeze clears itself.
// RQ4: the freeze reaches only the cpu stall output; every other peripheral keeps running.
// RQ5: interrupts during the freeze stay pending and are served by priority afterwards.
// RQ6: the converter works only while enabled and sits in low-power standby otherwise.
// RQ7: software waits the settling time after enabling before the first start.
// RQ8: writing start launches a conversion; start reads 1 until hardware clears it at the end.
// RQ9: a conversion lasts 11 converter clock periods from launch to result.
// RQ10: the end sets the done flag, which only software clears.
// RQ11: the interrupt request is the done flag gated by the interrupt enable.
// RQ12: the upper 8 result bits sit in the high register, the lower 2 in low register bits 1:0.
// RQ13: both result registers are read-only.
// RQ14: reserved bits read 0 and software leaves them at 0.
// RQ15: control, divider, high and low registers reset to 0.
// RQ16: both result registers load together at the end of a conversion.
// RQ17: a start written during a conversion neither restarts nor disturbs it.
module sar_adc_control
  import sar_adc_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // sfr port
  input wire sfr_req_s i_sfr,
  output logic [7:0] o_sfr_rdata,
  // interrupt enable bit from the second interrupt enable register
  input wire logic i_converter_interrupt_enable,
  // analog front end
  input wire logic i_comparator_high,
  output afe_ctrl_s o_afe,
  output logic [9:0] o_dac_code,
  // core and interrupt controller
  output logic o_cpu_freeze,
  output logic o_irq
);

  // register state
  logic [4:0] divider_value_q;
  logic freeze_q, enable_q, done_q, start_q, channel_q;
  logic [7:0] result_high_q;
  logic [1:0] result_low_q;
  conv_state_e state_q;
  // conversion engine
  logic [5:0] div_cnt_q;
  logic [3:0] period_q;
  logic [9:0] trial_q;
  logic [7:0] rdata_q;

  // decoding
  wire wr_ctrl = i_sfr.wr && (i_sfr.addr == ADDR_CONTROL);
  wire wr_div = i_sfr.wr && (i_sfr.addr == ADDR_CLOCK_DIVIDER);
  wire [7:0] wmask_ctrl = i_sfr.wdata & CTRL_WRITABLE_MASK;
  wire start_req = wr_ctrl && wmask_ctrl[CTRL_START_BIT];
  wire enable_next = wr_ctrl ? wmask_ctrl[CTRL_ENABLE_BIT] : enable_q;
  wire converting = (state_q == ST_CONVERTING);
  wire launch = start_req && enable_next && !converting; // RQ17 RQ6

  // converter clock tick: 0 selects a divide by 32
  wire [5:0] div_factor = (divider_value_q == DIVIDER_ZERO) ? DIVIDER_ZERO_FACTOR
                          : {1'b0, divider_value_q}; // RQ1
  wire adc_tick = converting && (div_cnt_q == div_factor - 6'h01); // RQ1
  wire last_period = adc_tick && (period_q == CONVERSION_PERIODS - 4'h1); // RQ9
  wire abort = converting && wr_ctrl && !wmask_ctrl[CTRL_ENABLE_BIT]; // RQ6

  // bit under trial during periods 1..10, period 0 is sampling
  function automatic logic [9:0] trial_bit(input logic [3:0] p);
    // period 1 tries the msb, period 10 the lsb
    trial_bit = (p == 4'h0 || p > 4'hA) ? 10'h000 : (10'h200 >> (p - 4'h1));
  endfunction

  wire [9:0] cur_bit = trial_bit(period_q);
  wire [9:0] next_bit = trial_bit(period_q + 4'h1);
  wire [9:0] kept = i_comparator_high ? trial_q : (trial_q & ~cur_bit);

  // control register; hardware set of done wins over a software clear
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      freeze_q <= 1'b0; // RQ15
      enable_q <= 1'b0;
      done_q <= 1'b0;
      channel_q <= 1'b0;
      divider_value_q <= 5'h00;
    end
    else
    begin
      if (wr_div)
        divider_value_q <= i_sfr.wdata[4:0] & DIVIDER_WRITABLE_MASK[4:0]; // RQ14
      if (wr_ctrl)
      begin
        enable_q <= wmask_ctrl[CTRL_ENABLE_BIT];
        if (!converting)
          channel_q <= wmask_ctrl[CTRL_CHANNEL_BIT]; // RQ17
        if (!converting || launch)
          freeze_q <= wmask_ctrl[CTRL_FREEZE_BIT];
      end
      if (last_period || abort)
        freeze_q <= 1'b0; // RQ3
      if (last_period)
        done_q <= 1'b1; // RQ10
      else if (wr_ctrl)
        done_q <= wmask_ctrl[CTRL_DONE_BIT];
    end
  end

  // sequencer
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q <= ST_STANDBY;
      start_q <= 1'b0;
      div_cnt_q <= 6'h00;
      period_q <= 4'h0;
      trial_q <= 10'h000;
    end
    else
    begin
      unique case (state_q)
        ST_STANDBY, ST_READY:
        begin
          state_q <= enable_next ? ST_READY : ST_STANDBY; // RQ6
          if (launch)
          begin
            state_q <= ST_CONVERTING; // RQ8
            start_q <= 1'b1;
            div_cnt_q <= 6'h00;
            period_q <= 4'h0;
            trial_q <= 10'h000;
          end
        end
        ST_CONVERTING:
        begin
          if (abort)
          begin
            state_q <= ST_STANDBY;
            start_q <= 1'b0;
          end
          else if (last_period)
          begin
            state_q <= ST_READY;
            start_q <= 1'b0; // RQ8
            trial_q <= kept;
          end
          else if (adc_tick)
          begin
            div_cnt_q <= 6'h00;
            period_q <= period_q + 4'h1;
            trial_q <= kept | next_bit;
          end
          else
            div_cnt_q <= div_cnt_q + 6'h01;
        end
        // the unused state code falls back to standby
        default:
        begin
          state_q <= ST_STANDBY;
          start_q <= 1'b0;
        end
      endcase
    end
  end

  // result registers load as one word
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      result_high_q <= 8'h00; // RQ15
      result_low_q <= 2'h0;
    end
    else if (last_period)
    begin
      // lsb decision is taken in the same edge, so load the kept code
      result_high_q <= kept[9:2]; // RQ12 RQ16
      result_low_q <= kept[1:0];
    end
  end

  // read data; writes to result addresses fall through unused
  wire [7:0] ctrl_view = {1'b0, freeze_q, enable_q, done_q, start_q, 2'b00, channel_q}; // RQ14
  wire [7:0] read_mux = (i_sfr.addr == ADDR_CONTROL) ? ctrl_view
                      : (i_sfr.addr == ADDR_CLOCK_DIVIDER) ? {3'b000, divider_value_q}
                      : (i_sfr.addr == ADDR_RESULT_HIGH) ? result_high_q
                      : (i_sfr.addr == ADDR_RESULT_LOW) ? ({6'h00, result_low_q} & LOW_WRITABLE_MASK)
                      : RESET_BYTE; // RQ13

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdata_q <= RESET_BYTE;
    else if (i_sfr.rd)
      rdata_q <= read_mux;
  end

  assign o_sfr_rdata = rdata_q;
  // only the core stalls; pending interrupts wait in the interrupt controller
  assign o_cpu_freeze = freeze_q && converting; // RQ3 RQ4 RQ5
  assign o_irq = done_q && i_converter_interrupt_enable; // RQ11
  assign o_dac_code = trial_q;
  assign o_afe.sample = converting && (period_q == 4'h0);
  assign o_afe.channel_second = !channel_q; // RQ2
  assign o_afe.powered = enable_q; // RQ6

endmodule

// >>> test/sar_afe_model.sv
// analog stand-in: sample and hold on two inputs feeding a comparator
// assumes the control drives the trial code and the channel choice
module sar_afe_model
  import sar_adc_pkg::*;
#(
  parameter logic [9:0] FIRST_IN = 10'h2A5,
  parameter logic [9:0] SECOND_IN = 10'h13C
)
(
  input wire afe_ctrl_s i_afe,
  input wire logic [9:0] i_dac_code,
  output logic o_comparator_high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held = 10'h000;
  always @*
    if (i_afe.sample)
      held = i_afe.channel_second ? SECOND_IN : FIRST_IN;
  // an unpowered comparator gives no steady answer
  assign o_comparator_high = i_afe.powered ? (held >= i_dac_code) : ^i_dac_code;
endmodule

// >>> test/sar_adc_checker.sv
// port checker for the converter control
// assumes one clock domain; bound to every instance of the control
module sar_adc_checker
  import sar_adc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire sfr_req_s i_sfr,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic i_converter_interrupt_enable,
  input wire afe_ctrl_s o_afe,
  input wire logic o_cpu_freeze,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  wire rd_div = i_sfr.rd && i_sfr.addr == ADDR_CLOCK_DIVIDER;
  wire wr_div = i_sfr.wr && i_sfr.addr == ADDR_CLOCK_DIVIDER;
  wire wr_ctl = i_sfr.wr && i_sfr.addr == ADDR_CONTROL;
  wire en_bit = i_sfr.wdata[5];
  irq_gate_a: assert property (o_irq |-> i_converter_interrupt_enable)
    else $error("irq without enable");
  standby_quiet_a: assert property (!o_afe.powered |-> !o_afe.sample && !o_cpu_freeze)
    else $error("activity in standby");
  freeze_start_a: assert property ($rose(o_cpu_freeze) |-> o_afe.sample)
    else $error("freeze outside launch");
  ctrl_reserved_a: assert property (i_sfr.rd && i_sfr.addr == ADDR_CONTROL
    |=> (o_sfr_rdata & 8'h86) == 8'h00) else $error("control reserved set");
  low_reserved_a: assert property (i_sfr.rd && i_sfr.addr == ADDR_RESULT_LOW
    |=> o_sfr_rdata[7:2] == 6'h00) else $error("low reserved set");
  div_readback_a: assert property (wr_div ##1 rd_div
    |=> o_sfr_rdata == ($past(i_sfr.wdata, 2) & 8'h1F)) else $error("divider readback");
  enable_write_a: assert property (wr_ctl |=> o_afe.powered == $past(en_bit))
    else $error("enable not applied");
  rdata_hold_a: assert property (!i_sfr.rd |=> $stable(o_sfr_rdata))
    else $error("read data moved");
  cover property (o_irq);
  cover property ($fell(o_cpu_freeze));
  cover property (wr_div ##1 rd_div);
endmodule
bind sar_adc_control sar_adc_checker u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sfr(i_sfr),
  .o_sfr_rdata(o_sfr_rdata), .i_converter_interrupt_enable(i_converter_interrupt_enable),
  .o_afe(o_afe), .o_cpu_freeze(o_cpu_freeze), .o_irq(o_irq));

// >>> test/test_sar_adc_control.sv
// self-checking bench for the converter control with the analog stand-in
// assumes the checker binds itself; reads are compared from a queue
module test_sar_adc_control;
  import sar_adc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, irq_en = 1'b0, pend = 1'b0;
  logic cmp, freeze, irq;
  sfr_req_s i_sfr = '0;
  logic [7:0] rdata, c;
  logic [7:0] expq[$];
  logic [9:0] dac, v;
  logic [4:0] dv;
  afe_ctrl_s afe;
  int num_errors = 0, num_checks = 0, f;
  always #4 i_mclk = ~i_mclk;
  sar_adc_control u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sfr(i_sfr),
    .o_sfr_rdata(rdata), .i_converter_interrupt_enable(irq_en), .i_comparator_high(cmp),
    .o_afe(afe), .o_dac_code(dac), .o_cpu_freeze(freeze), .o_irq(irq));
  sar_afe_model u_afe (.i_afe(afe), .i_dac_code(dac), .o_comparator_high(cmp));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize();
    if (num_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    i_sfr <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge i_mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask
  task automatic idle(input int n);
    i_sfr <= '0;
    repeat (n) @(posedge i_mclk);
  endtask
  // negedge sampling keeps the compare clear of the edge that loads read data
  always @(negedge i_mclk)
  begin
    if (pend)
      chk("sfr read", expq.pop_front(), rdata);
    pend = i_sfr.rd;
  end
  initial
  begin
    repeat (20000) @(posedge i_mclk);
    num_errors++;
    summarize();
  end
  initial
  begin
    void'($urandom(32'h223F));
    repeat (16) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    for (int a = 8'hF2; a < 8'hF7; a++)
      rd(8'(a), 8'h00);
    acc(1'b1, ADDR_RESULT_HIGH, 8'hFF);
    acc(1'b1, ADDR_RESULT_LOW, 8'h03);
    rd(ADDR_RESULT_HIGH, 8'h00);
    rd(ADDR_RESULT_LOW, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      dv = i ? 5'h00 : 5'($urandom_range(31, 2));
      f = i ? 32 : int'(dv);
      v = i ? 10'h2A5 : 10'h13C;
      c = i ? 8'h69 : 8'h28;
      irq_en <= i[0];
      acc(1'b1, ADDR_CLOCK_DIVIDER, {3'b000, dv});
      rd(ADDR_CLOCK_DIVIDER, {3'b000, dv});
      acc(1'b1, ADDR_CONTROL, {7'h10, i[0]});
      idle(4);
      acc(1'b1, ADDR_CONTROL, c);
      acc(1'b1, ADDR_CONTROL, 8'h28);
      rd(ADDR_CONTROL, c);
      chk("freeze", {7'h00, i[0]}, {7'h00, freeze});
      idle(11 * f - 4);
      rd(ADDR_CONTROL, c);
      idle(1);
      rd(ADDR_CONTROL, c & 8'h21 | 8'h10);
      rd(ADDR_RESULT_HIGH, v[9:2]);
      rd(ADDR_RESULT_LOW, {6'h00, v[1:0]});
      chk("irq", {7'h00, i[0]}, {7'h00, irq});
      chk("freeze", 8'h00, {7'h00, freeze});
      acc(1'b1, ADDR_CONTROL, 8'h00);
      idle(2);
      chk("irq", 8'h00, {7'h00, irq});
    end
    summarize();
  end
endmodule
